// ---- psvp_pkg.sv ----
// constants, types and timing for the serial program/verify port
package psvp_pkg;

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam logic [31:0] KEY_VALUE = 32'h4d434850;
	localparam logic [4:0] KEY_LAST = 5'h1f;
	localparam logic [4:0] CMD_LAST = 5'h03;
	localparam logic [4:0] OUT_FIRST = 5'h0c;
	localparam logic [4:0] FRAME_LAST = 5'h13;
	localparam int PTR_W = 22;

	// ----------------------------------------------------------------
	// commands and special table addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_CORE = 4'h0;
	localparam logic [3:0] CMD_SHIFT_LATCH = 4'h2;
	localparam logic [3:0] CMD_TR = 4'h8;
	localparam logic [3:0] CMD_TR_POSTINC = 4'h9;
	localparam logic [3:0] CMD_TR_POSTDEC = 4'ha;
	localparam logic [3:0] CMD_TR_PREINC = 4'hb;
	localparam logic [3:0] CMD_TW = 4'hc;
	localparam logic [3:0] CMD_TW_INC2 = 4'hd;
	localparam logic [3:0] CMD_TW_PROG_INC2 = 4'he;
	localparam logic [3:0] CMD_TW_PROG = 4'hf;
	localparam logic [21:0] BULK_ADDR_HI = 22'h3c0005;
	localparam logic [21:0] BULK_ADDR_LO = 22'h3c0004;
	localparam logic [15:0] BULK_CODE = 16'h0180;
	localparam logic [21:0] ROW_MASK = 22'h0003ff;

	// ----------------------------------------------------------------
	// apb register map and control fields
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_POINTER = 12'h000;
	localparam logic [11:0] OFS_LATCH = 12'h004;
	localparam logic [11:0] OFS_CONTROL = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam int FC_WR = 1;
	localparam int FC_WRITE_ENABLE_BIT = 2;
	localparam int FC_FREE = 4;

	// ----------------------------------------------------------------
	// timing, in ns, and derived cycle counts at pclk
	// ----------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int T_P9_NS = 1000000;
	localparam int T_P10_NS = 20000000;
	localparam int T_P11_NS = 100000000;
	localparam int T_P12_NS = 400;
	localparam int P9_CYC = (T_P9_NS + CLK_NS - 1) / CLK_NS;
	localparam int P10_CYC = (T_P10_NS + CLK_NS - 1) / CLK_NS;
	localparam int P11_CYC = (T_P11_NS + CLK_NS - 1) / CLK_NS;
	localparam int P12_CYC = (T_P12_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 24;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		M_KEY = 3'b000,
		M_RUN = 3'b001,
		M_LOCK = 3'b010,
		M_ARMED = 3'b011,
		M_PROG = 3'b100
	} psvp_mode_t;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_PROG = 2'b01,
		OP_ROW = 2'b10,
		OP_BULK = 2'b11
	} psvp_op_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [21:0] addr;
		logic [15:0] wdata;
	} psvp_mem_req_t;

	typedef struct packed {
		logic start;
		psvp_op_t op;
		logic [21:0] addr;
		logic clr_protect;
	} psvp_flash_cmd_t;

endpackage

// ---- psvp_sync.sv ----
// two-stage synchroniser for the programming pins
`timescale 1ns/1ps
module psvp_sync
	import psvp_pkg::*;
#(
	parameter int WIDTH = 3
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} psvp_sync_state_t;

	psvp_sync_state_t s;
	psvp_sync_state_t next_s;

	// first stage feeds only the second
	always_comb
	begin
		next_s.s1 = din;
		next_s.s2 = s.s1;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign dout = s.s2;

endmodule // psvp_sync

// ---- psvp_timer.sv ----
// countdown timer for self-timed flash operations and entry guard
`timescale 1ns/1ps
module psvp_timer
	import psvp_pkg::*;
#(
	parameter int WIDTH = CNT_W
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	// status
	output logic busy,
	output logic done
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic busy;
		logic done;
	} psvp_tmr_state_t;

	psvp_tmr_state_t s;
	psvp_tmr_state_t next_s;

	// busy for exactly count cycles (one cycle for a zero count), then one done pulse
	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		if (load)
		begin
			next_s.cnt = (count == '0) ? WIDTH'(1) : count;
			next_s.busy = 1'b1;
		end
		else if (s.busy)
		begin
			next_s.cnt = s.cnt - WIDTH'(1);
			if (s.cnt == WIDTH'(1))
			begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign busy = s.busy;
	assign done = s.done;

endmodule // psvp_timer

// ---- psvp_port.sv ----
// serial program/verify port: key entry, 20-bit frames, table access, flash launch
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps

// How it works
// (RULE1) programmer pulses enable, shifts key, re-raises enable
// (RULE2) programmer waits before shifting key bits
// (RULE3) enter mode only on exact key match
// (RULE4) key is MSB first, frames LSB first
// (RULE5) enable held; early frame bits ignored briefly
// (RULE6) unused pins high impedance while in mode
// (RULE7) programmer drops enable to leave the mode
// (RULE8) enable without key runs the application
// (RULE9) data sampled on serial clock falling edge
// (RULE10) frame is 4-bit command plus 16-bit operand
// (RULE11) reads: 8 bits in, 8 bits driven out
// (RULE12) decode core, latch-shift and four table reads
// (RULE13) decode four table write variants
// (RULE14) core command passes operand as an opcode
// (RULE15) write enable needed before write or erase; the bulk erase pair sets up bulk erase without it
// (RULE16) write start launches; erase select picks erase
// (RULE17) 0180h written at the erase pair requests bulk erase
// (RULE18) bulk erase clears protection; row erase never does
// (RULE19) bulk erase freezes serial logic from fourth fall
// (RULE20) row erase clears aligned 1024-byte row
// (RULE21) row erase runs while clock held high
// (RULE22) programmer fixes config bit after last row erase
// (RULE23) table pointer is 22 bits from three bytes
// (RULE24) bad key locks port until enable cycles
module psvp_port
	import psvp_pkg::*;
#(
	parameter int PROG_CYC = P9_CYC,
	parameter int ROW_CYC = P10_CYC,
	parameter int BULK_CYC = P11_CYC,
	parameter int GUARD_CYC = P12_CYC
)
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// programming pins
	input wire logic program_enable_pin,
	input wire logic serial_prog_clock,
	input wire logic serial_prog_data_in,
	output logic serial_prog_data_out,
	output logic serial_prog_data_oe,
	// core instruction injection
	output logic [15:0] core_opcode,
	output logic core_opcode_valid,
	// table memory access
	output psvp_mem_req_t mem_req,
	input wire logic [7:0] mem_rd_data,
	// flash operation launch
	output psvp_flash_cmd_t flash_cmd,
	input wire logic code_protected,
	// device mode
	output logic app_run,
	output logic io_hiz
);

	typedef struct packed {
		psvp_mode_t mode;
		logic en_q;
		logic clk_q;
		logic [31:0] key_sr;
		logic [4:0] key_cnt;
		logic [4:0] bit_cnt;
		logic [3:0] cmd;
		logic [15:0] opnd;
		logic [PTR_W-1:0] table_pointer;
		logic [7:0] table_latch;
		logic [7:0] out_sr;
		logic dout;
		logic doe;
		logic rd_pend;
		logic write_enable_bit;
		logic free;
		logic wr;
		logic [7:0] bulk_hi;
		psvp_op_t pend;
		logic [PTR_W-1:0] pend_addr;
		logic busy;
		logic guard;
		logic [15:0] core_op;
		logic core_vld;
		psvp_mem_req_t mem;
		psvp_flash_cmd_t flash;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic app_run;
		logic io_hiz;
	} psvp_state_t;

	psvp_state_t s;
	psvp_state_t next_s;

	logic [2:0] pins;
	logic s_en;
	logic s_clk;
	logic s_dat;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_count;
	logic tmr_busy;
	logic tmr_done;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// address decode shared by read and write paths: {hit, index}
	function automatic logic [2:0] reg_sel(input logic [11:0] a);
		unique case (a)
			OFS_POINTER: reg_sel = 3'h4;
			OFS_LATCH: reg_sel = 3'h5;
			OFS_CONTROL: reg_sel = 3'h6;
			OFS_STATUS: reg_sel = 3'h7;
			default: reg_sel = 3'h0;
		endcase
	endfunction

	// self-timed duration for each flash operation
	function automatic logic [CNT_W-1:0] op_cycles(input psvp_op_t op);
		unique case (op)
			OP_ROW: op_cycles = CNT_W'(ROW_CYC);
			OP_BULK: op_cycles = CNT_W'(BULK_CYC);
			default: op_cycles = CNT_W'(PROG_CYC);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers and timer
	// ----------------------------------------------------------------
	psvp_sync #(.WIDTH(3)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({program_enable_pin, serial_prog_clock, serial_prog_data_in}),
		.dout(pins)
	);

	assign s_en = pins[2];
	assign s_clk = pins[1];
	assign s_dat = pins[0];

	psvp_timer #(.WIDTH(CNT_W)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(tmr_load),
		.count(tmr_count),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		logic en_rise;
		logic en_fall;
		logic clk_rise;
		logic clk_fall;
		logic launch;
		logic [2:0] sel;
		logic [3:0] cmd_now;
		logic [15:0] opnd_now;
		logic [31:0] fc_word;
		en_rise = s_en & ~s.en_q;
		en_fall = ~s_en & s.en_q;
		clk_rise = s_clk & ~s.clk_q;
		clk_fall = ~s_clk & s.clk_q;
		launch = 1'b0;
		sel = reg_sel(paddr);
		cmd_now = {s_dat, s.cmd[3:1]};
		opnd_now = {s_dat, s.opnd[15:1]};
		fc_word = '0;
		fc_word[FC_WR] = s.wr;
		fc_word[FC_WRITE_ENABLE_BIT] = s.write_enable_bit;
		fc_word[FC_FREE] = s.free;
		next_s = s;
		tmr_load = 1'b0;
		tmr_count = '0;
		next_s.en_q = s_en;
		next_s.clk_q = s_clk;
		next_s.core_vld = 1'b0;
		next_s.mem.rd = 1'b0;
		next_s.mem.wr = 1'b0;
		next_s.flash.start = 1'b0;

		// read data comes back the cycle after the request
		if (s.rd_pend)
		begin
			next_s.table_latch = mem_rd_data;
			next_s.rd_pend = 1'b0;
		end

		// end of a self-timed phase; write-start clears when flash is done
		if (tmr_done)
		begin
			if (s.guard)
				next_s.guard = 1'b0;
			else
			begin
				next_s.busy = 1'b0;
				next_s.wr = 1'b0;
			end
		end

		// apb: one wait state, answer registered
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		if (psel && penable && !s.pready)
		begin
			next_s.pready = 1'b1;
			next_s.pslverr = ~sel[2];
			unique case (sel)
				3'h4: next_s.prdata = {10'h000, s.table_pointer}; // (RULE23)
				3'h5: next_s.prdata = {24'h000000, s.table_latch};
				3'h6: next_s.prdata = fc_word;
				3'h7: next_s.prdata = {26'h0000000, s.pend != OP_NONE, s.guard, s.busy, s.mode};
				default: next_s.prdata = 32'h00000000;
			endcase
		end
		// write takes effect on the completing edge; a register write beats the hardware clear above
		if (psel && penable && pwrite && s.pready)
		begin
			unique case (sel)
				3'h4: next_s.table_pointer = pwdata[PTR_W-1:0];
				3'h5: next_s.table_latch = pwdata[7:0];
				3'h6:
				begin
					next_s.write_enable_bit = pwdata[FC_WRITE_ENABLE_BIT];
					next_s.free = pwdata[FC_FREE];
					// write-start only with write enable already set
					if (pwdata[FC_WR] && s.write_enable_bit && !s.busy && s.pend == OP_NONE) // (RULE15)
					begin
						if (pwdata[FC_FREE])
						begin
							// protected rows are refused so protection survives
							if (!code_protected) // (RULE18)
							begin
								next_s.pend = OP_ROW; // (RULE16)
								next_s.pend_addr = s.table_pointer & ~ROW_MASK; // (RULE20)
								next_s.wr = 1'b1;
							end
						end
						else
						begin
							next_s.pend = OP_PROG; // (RULE16)
							next_s.pend_addr = s.table_pointer;
							next_s.wr = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// mode sequencing
		// ------------------------------------------------------------
		unique case (s.mode)
			M_KEY:
			begin
				if (en_rise)
					next_s.mode = M_RUN; // (RULE8)
				else if (clk_fall)
				begin
					next_s.key_sr = {s.key_sr[30:0], s_dat}; // (RULE4)
					next_s.key_cnt = s.key_cnt + 5'h01;
					if (s.key_cnt == KEY_LAST)
						next_s.mode = ({s.key_sr[30:0], s_dat} == KEY_VALUE) ? M_ARMED : M_LOCK; // (RULE3)
				end
			end
			M_ARMED:
			begin
				if (en_rise)
				begin
					// ignore the link briefly after entry
					next_s.mode = M_PROG;
					next_s.guard = 1'b1; // (RULE5)
					next_s.bit_cnt = 5'h00;
					tmr_load = 1'b1;
					tmr_count = CNT_W'(GUARD_CYC);
				end
			end
			M_LOCK:
			begin
				// serial activity ignored until enable is cycled
				if (en_rise)
					next_s.mode = M_RUN; // (RULE24)
			end
			M_RUN:
			begin
				if (en_fall)
				begin
					next_s.mode = M_KEY;
					next_s.key_cnt = 5'h00;
				end
			end
			M_PROG:
			begin
				if (en_fall)
				begin
					// leaving the mode drops any frame or pending launch
					next_s.mode = M_KEY;
					next_s.key_cnt = 5'h00;
					next_s.bit_cnt = 5'h00;
					next_s.doe = 1'b0;
					next_s.pend = OP_NONE;
				end
				else if (!s.busy && !s.guard) // (RULE19)
				begin
					// readback bits change on the rising edge
					if (clk_rise)
					begin
						if (s.bit_cnt == CMD_LAST && s.pend != OP_NONE && s.pend != OP_BULK)
							launch = 1'b1; // (RULE21)
						if (s.bit_cnt == OUT_FIRST && (s.cmd == CMD_SHIFT_LATCH || s.cmd[3:2] == 2'b10))
						begin
							next_s.doe = 1'b1; // (RULE11)
							next_s.dout = s.table_latch[0];
							next_s.out_sr = {1'b0, s.table_latch[7:1]};
						end
						else if (s.doe)
						begin
							next_s.dout = s.out_sr[0];
							next_s.out_sr = {1'b0, s.out_sr[7:1]};
						end
					end
					// frame bits sampled on the falling edge, lsb first
					if (clk_fall) // (RULE9)
					begin
						next_s.bit_cnt = s.bit_cnt + 5'h01;
						if (s.bit_cnt <= CMD_LAST)
							next_s.cmd = cmd_now;
						else
							next_s.opnd = opnd_now; // (RULE10)
						if (s.bit_cnt == CMD_LAST)
						begin
							if (s.pend == OP_BULK)
								launch = 1'b1; // (RULE19)
							// table reads fetch once the command is known
							unique case (cmd_now) // (RULE12)
								CMD_TR, CMD_TR_POSTINC, CMD_TR_POSTDEC:
								begin
									next_s.mem.rd = 1'b1;
									next_s.mem.addr = s.table_pointer;
									next_s.rd_pend = 1'b1;
									if (cmd_now == CMD_TR_POSTINC)
										next_s.table_pointer = s.table_pointer + 22'h000001;
									if (cmd_now == CMD_TR_POSTDEC)
										next_s.table_pointer = s.table_pointer - 22'h000001;
								end
								CMD_TR_PREINC:
								begin
									next_s.mem.rd = 1'b1;
									next_s.mem.addr = s.table_pointer + 22'h000001;
									next_s.rd_pend = 1'b1;
									next_s.table_pointer = s.table_pointer + 22'h000001;
								end
								default: ;
							endcase
						end
						if (s.bit_cnt == FRAME_LAST)
						begin
							next_s.bit_cnt = 5'h00;
							next_s.doe = 1'b0;
							unique case (s.cmd)
								CMD_CORE:
								begin
									next_s.core_op = opnd_now; // (RULE14)
									next_s.core_vld = 1'b1;
								end
								CMD_TW, CMD_TW_INC2, CMD_TW_PROG_INC2, CMD_TW_PROG: // (RULE13)
								begin
									next_s.mem.wr = 1'b1;
									next_s.mem.addr = s.table_pointer;
									next_s.mem.wdata = opnd_now;
									// erase pair: 01h then 80h forms the bulk code
									if (s.table_pointer == BULK_ADDR_HI)
										next_s.bulk_hi = opnd_now[7:0];
									if (s.table_pointer == BULK_ADDR_LO && {s.bulk_hi, opnd_now[7:0]} == BULK_CODE)
										next_s.pend = OP_BULK; // (RULE17)
									if (s.cmd == CMD_TW_INC2 || s.cmd == CMD_TW_PROG_INC2)
										next_s.table_pointer = s.table_pointer + 22'h000002;
									if (s.cmd[1] && s.write_enable_bit) // (RULE15)
									begin
										next_s.pend = OP_PROG;
										next_s.pend_addr = s.table_pointer;
										next_s.wr = 1'b1;
									end
								end
								default: ;
							endcase
						end
					end
				end
			end
			default: next_s.mode = M_KEY;
		endcase

		// ------------------------------------------------------------
		// flash launch: serial logic frozen until the timer ends
		// ------------------------------------------------------------
		if (launch)
		begin
			next_s.flash.start = 1'b1;
			next_s.flash.op = s.pend;
			next_s.flash.addr = s.pend_addr;
			next_s.flash.clr_protect = (s.pend == OP_BULK); // (RULE18)
			next_s.busy = 1'b1;
			next_s.pend = OP_NONE;
			tmr_load = 1'b1;
			tmr_count = op_cycles(s.pend);
		end

		next_s.app_run = (next_s.mode == M_RUN);
		next_s.io_hiz = (next_s.mode == M_PROG); // (RULE6)
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	// outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign serial_prog_data_out = s.dout;
	assign serial_prog_data_oe = s.doe;
	assign core_opcode = s.core_op;
	assign core_opcode_valid = s.core_vld;
	assign mem_req = s.mem;
	assign flash_cmd = s.flash;
	assign app_run = s.app_run;
	assign io_hiz = s.io_hiz;

endmodule // psvp_port

// ---- psvp_port_chk.sv ----
// assertion checker for the serial program/verify port
`timescale 1ns/1ps
module psvp_port_chk
	import psvp_pkg::*;
(
	// clock, reset and apb answer
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// pins and mode
	input wire logic program_enable_pin,
	input wire logic serial_prog_clock,
	input wire logic serial_prog_data_oe,
	input wire logic app_run,
	input wire logic io_hiz,
	// core, memory and flash
	input wire logic core_opcode_valid,
	input wire psvp_mem_req_t mem_req,
	input wire psvp_flash_cmd_t flash_cmd,
	input wire logic code_protected
);
	// ----
	// properties, one clock domain
	// ----
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_one_wait: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
	a_bulk_quiet: assert property (flash_cmd.start && flash_cmd.op == OP_BULK |=>
		(!(core_opcode_valid || mem_req.rd || mem_req.wr)) [*8]) else $error("serial work during bulk erase");
	a_exit_hiz: assert property (!program_enable_pin [*5] |-> !io_hiz) else $error("pins stay high-z");
	a_oe_on_rise: assert property ($rose(serial_prog_data_oe) |-> $past(serial_prog_clock, 2))
		else $error("data driven off the rising clock");
	a_oe_in_mode: assert property (serial_prog_data_oe |-> io_hiz) else $error("data driven outside mode");
	a_core_pulse: assert property (core_opcode_valid |-> io_hiz ##1 !core_opcode_valid)
		else $error("bad core opcode pulse");
	a_write_in_mode: assert property (mem_req.wr |-> io_hiz) else $error("table write outside mode");
	a_read_pulse: assert property (mem_req.rd |=> !mem_req.rd) else $error("table read pulse too long");
	a_row_aligned: assert property (flash_cmd.start && flash_cmd.op == OP_ROW |->
		!flash_cmd.clr_protect && (flash_cmd.addr & ROW_MASK) == 22'h0) else $error("row erase misaligned");
	a_row_refused: assert property (flash_cmd.start && flash_cmd.op == OP_ROW |-> !code_protected)
		else $error("row erase on protected code");
	a_bulk_unprot: assert property (flash_cmd.start && flash_cmd.op == OP_BULK |-> flash_cmd.clr_protect)
		else $error("bulk erase keeps protection");
	a_mode_excl: assert property (!(io_hiz && app_run)) else $error("run and program mode together");
	c_bulk: cover property (flash_cmd.start && flash_cmd.op == OP_BULK);
	c_row: cover property (flash_cmd.start && flash_cmd.op == OP_ROW);
	c_read: cover property ($rose(serial_prog_data_oe));
endmodule // psvp_port_chk

bind psvp_port psvp_port_chk i_psvp_port_chk (.pclk, .presetn, .psel, .penable, .pready, .program_enable_pin,
	.serial_prog_clock, .serial_prog_data_oe, .app_run, .io_hiz, .core_opcode_valid, .mem_req, .flash_cmd,
	.code_protected);

// ---- psvp_prog_model.sv ----
// behavioural external programmer on the serial pins
`timescale 1ns/1ps
module psvp_prog_model
	import psvp_pkg::*;
(
	// pins driven towards the device
	output logic program_enable_pin,
	output logic serial_prog_clock,
	output logic data_drive,
	// resolved data pin level
	input wire logic data_pin
);
	// clock stands low outside frames
	initial
	begin
		program_enable_pin = 1'h0;
		serial_prog_clock = 1'h0;
		data_drive = 1'h0;
	end
	// one key bit: data moves with the rise, taken at the fall
	task automatic shift(input logic b);
		serial_prog_clock = 1'h1;
		data_drive = b;
		#100;
		serial_prog_clock = 1'h0;
		#100;
	endtask
	// enable pulse, key msb first, enable held
	task automatic enter(input logic [31:0] key);
		program_enable_pin = 1'h1;
		#400;
		program_enable_pin = 1'h0;
		#400;
		for (int i = 31; i >= 0; i--)
			shift(key[i]);
		program_enable_pin = 1'h1;
		#400;
	endtask
	// 20-bit frame lsb first; hold stretches the fourth cycle
	task automatic frame(input logic [3:0] cmd, input logic [15:0] op, input int hold, input logic hold_hi,
		output logic [7:0] rd);
		logic [19:0] bits;
		logic rdc;
		bits = {op, cmd};
		rdc = (cmd == CMD_SHIFT_LATCH) || (cmd[3:2] == 2'h2);
		rd = 8'h00;
		for (int i = 0; i < 20; i++)
		begin
			serial_prog_clock = 1'h1;
			// released line toggles so a stale level never passes
			data_drive = (rdc && i >= 12) ? ~data_drive : bits[i];
			#90;
			// read late in the high phase, clear of the device turning its driver off
			if (rdc && i >= 12)
				rd[i - 12] = data_pin;
			#10;
			if (i == 3 && hold_hi)
				#(hold);
			serial_prog_clock = 1'h0;
			#100;
			if (i == 3 && !hold_hi)
				#(hold);
		end
	endtask
	// quiet gap, then enable low
	task automatic leave();
		#400;
		program_enable_pin = 1'h0;
		#400;
	endtask
endmodule // psvp_prog_model

// ---- psvp_port_bench.sv ----
// self-checking bench for the serial program/verify port
`timescale 1ns/1ps
module psvp_port_bench;
	import psvp_pkg::*;
	// ----
	// signals and instances
	// ----
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, code_protected, app_run, io_hiz;
	logic program_enable_pin, serial_prog_clock, data_drive, serial_prog_data_in;
	logic serial_prog_data_out, serial_prog_data_oe, core_opcode_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] core_opcode, w, wr_data;
	logic [21:0] p, wr_addr;
	logic [7:0] mem_rd_data, rd;
	psvp_mem_req_t mem_req;
	psvp_flash_cmd_t flash_cmd, fc;
	int mismatches, cmp_count, fc_cnt, core_cnt;
	assign serial_prog_data_in = serial_prog_data_oe ? serial_prog_data_out : data_drive;
	psvp_port #(.PROG_CYC(20), .ROW_CYC(30), .BULK_CYC(40), .GUARD_CYC(4)) i_psvp_port (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .program_enable_pin, .serial_prog_clock,
		.serial_prog_data_in, .serial_prog_data_out, .serial_prog_data_oe, .core_opcode, .core_opcode_valid,
		.mem_req, .mem_rd_data, .flash_cmd, .code_protected, .app_run, .io_hiz);
	psvp_prog_model i_psvp_prog_model (.program_enable_pin, .serial_prog_clock, .data_drive,
		.data_pin(serial_prog_data_in));
	// 40 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end
	// ----
	// memory model, pulse capture, helpers
	// ----
	function automatic logic [7:0] mem_byte(input logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction
	assign mem_rd_data = mem_byte(mem_req.addr);
	// one-cycle pulses are caught at the edge they stand
	always @(posedge pclk)
	begin
		if (core_opcode_valid === 1'h1)
			core_cnt++;
		if (mem_req.wr === 1'h1)
			{wr_addr, wr_data} <= {mem_req.addr, mem_req.wdata};
		if (flash_cmd.start === 1'h1)
		begin
			fc <= flash_cmd;
			fc_cnt++;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// apb master: hold the request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		r = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// one frame, then room for the action to land
	task automatic fr(input logic [3:0] cmd, input logic [15:0] op, input int hold, input logic hi);
		i_psvp_prog_model.frame(cmd, op, hold, hi, rd);
		repeat (4) @(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, well beyond the expected run
	initial
	begin
		#400000;
		mismatches++;
		give_verdict();
	end
	// ----
	// scenarios
	// ----
	initial
	begin
		{psel, penable, pwrite, code_protected, presetn} = 5'h0;
		{paddr, pwdata} = 44'h0;
		void'($urandom(27069));
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 12'h010, 32'h0);
		chk(r, 32'h0);
		chk(32'(err), 32'h1);
		// wrong key: never reaches program mode
		i_psvp_prog_model.enter(~KEY_VALUE);
		fr(CMD_CORE, 16'h1234, 0, 1'h0);
		chk(32'(core_cnt), 32'h0);
		chk(32'({app_run, io_hiz}), 32'h2);
		i_psvp_prog_model.leave();
		i_psvp_prog_model.enter(KEY_VALUE);
		chk(32'({app_run, io_hiz}), 32'h1);
		apb(1'h0, OFS_STATUS, 32'h0);
		chk(32'(r[2:0]), 32'(M_PROG));
		for (int k = 0; k < 3; k++)
		begin
			w = 16'($urandom);
			fr(CMD_CORE, w, 0, 1'h0);
			chk(32'(core_opcode), 32'(w));
		end
		// four table reads; post-decrement from zero wraps
		for (int k = 0; k < 4; k++)
		begin
			p = (k == 2) ? 22'h0 : 22'($urandom);
			apb(1'h1, OFS_POINTER, 32'(p));
			fr(CMD_TR + 4'(k), 16'h0, 0, 1'h0);
			chk(32'(rd), 32'(mem_byte(22'(k == 3 ? p + 1 : p))));
			apb(1'h0, OFS_POINTER, 32'h0);
			chk(r, 32'(22'(k == 0 ? p : k == 2 ? p - 1 : p + 1)));
		end
		w = 16'($urandom);
		apb(1'h1, OFS_LATCH, 32'(w[7:0]));
		fr(CMD_SHIFT_LATCH, 16'h0, 0, 1'h0);
		chk(32'(rd), 32'(w[7:0]));
		for (int k = 0; k < 2; k++)
		begin
			p = 22'($urandom);
			w = 16'($urandom);
			apb(1'h1, OFS_POINTER, 32'(p));
			fr(CMD_TW + 4'(k), w, 0, 1'h0);
			chk(32'(wr_addr), 32'(p));
			chk(32'(wr_data), 32'(w));
			apb(1'h0, OFS_POINTER, 32'h0);
			chk(r, 32'(22'(p + 2 * k)));
		end
		// bulk erase pair, then a nop with data low
		apb(1'h1, OFS_POINTER, 32'(BULK_ADDR_HI));
		fr(CMD_TW, 16'h0101, 0, 1'h0);
		apb(1'h1, OFS_POINTER, 32'(BULK_ADDR_LO));
		fr(CMD_TW, 16'h8080, 0, 1'h0);
		fr(CMD_CORE, 16'h0, 1200, 1'h0);
		chk(32'({fc_cnt[3:0], fc.op, fc.clr_protect}), 32'({4'h1, OP_BULK, 1'h1}));
		// row erase: refused without write enable, then done
		p = 22'($urandom);
		apb(1'h1, OFS_POINTER, 32'(p));
		apb(1'h1, OFS_CONTROL, 32'h12);
		fr(CMD_CORE, 16'h0, 1200, 1'h1);
		chk(32'(fc_cnt), 32'h1);
		apb(1'h1, OFS_CONTROL, 32'h14);
		apb(1'h1, OFS_CONTROL, 32'h16);
		fr(CMD_CORE, 16'h0, 1200, 1'h1);
		chk(32'({fc_cnt[3:0], fc.op}), 32'({4'h2, OP_ROW}));
		chk(32'(fc.addr), 32'(p & ~ROW_MASK));
		code_protected <= 1'h1;
		apb(1'h1, OFS_CONTROL, 32'h16);
		fr(CMD_CORE, 16'h0, 1200, 1'h1);
		chk(32'(fc_cnt), 32'h2);
		code_protected <= 1'h0;
		apb(1'h1, OFS_CONTROL, 32'h04);
		// after the last row: config high byte written with bit 3 low
		fr(CMD_TW_PROG, w & 16'hf7ff, 0, 1'h0);
		chk(32'(wr_data), 32'(w & 16'hf7ff));
		fr(CMD_CORE, 16'h0, 1200, 1'h1);
		chk(32'({fc_cnt[3:0], fc.op}), 32'({4'h3, OP_PROG}));
		i_psvp_prog_model.leave();
		repeat (8) @(posedge pclk);
		chk(32'(io_hiz), 32'h0);
		give_verdict();
	end
endmodule // psvp_port_bench
